// >>> hw/arc_pkg.sv
package arc_pkg;

  // ****************************************************************
  // Bus and register map
  // ****************************************************************
  localparam int ARC_ADDR_W = 16;
  localparam int ARC_DATA_W = 32;
  // Register indices; byte address is four times the index
  localparam logic [11:0] ARC_IDX_CTRL = 12'hf70;
  localparam logic [11:0] ARC_IDX_RAW_HIGH = 12'hf71;
  localparam logic [11:0] ARC_IDX_HELD_HIGH = 12'hf72;
  localparam logic [11:0] ARC_IDX_HELD_LOW = 12'hf73;
  localparam logic [11:0] ARC_IDX_SETTLE = 12'hf74;
  localparam logic [11:0] ARC_IDX_HOLD = 12'hf75;
  localparam logic [11:0] ARC_IDX_PRESCALE = 12'hf76;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int ARC_CTRL_START_BIT = 7;
  localparam int ARC_CTRL_ON_BIT = 4;
  localparam int ARC_CTRL_CHAN_LSB = 0;
  localparam int ARC_CHAN_W = 3;
  localparam int ARC_LOW_LSB = 6;
  localparam int ARC_SETTLE_W = 5;
  localparam int ARC_HOLD_W = 6;
  localparam int ARC_PRESCALE_W = 4;
  localparam int ARC_RESULT_W = 10;
  // Prescale bit positions
  localparam int ARC_PS_TWO = 0;
  localparam int ARC_PS_FOUR = 1;
  localparam int ARC_PS_EIGHT = 2;
  localparam int ARC_PS_SIXTEEN = 3;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] ARC_CTRL_RESET = 8'h00;
  localparam logic [ARC_SETTLE_W-1:0] ARC_SETTLE_RESET = 5'h1f;
  localparam logic [ARC_HOLD_W-1:0] ARC_HOLD_RESET = 6'h3f;
  localparam logic [ARC_PRESCALE_W-1:0] ARC_PRESCALE_RESET = 4'h0;

  // AXI responses
  localparam logic [1:0] ARC_RESP_OKAY = 2'h0;
  localparam logic [1:0] ARC_RESP_SLVERR = 2'h2;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    ARC_IDLE = 2'b00,
    ARC_SETTLE = 2'b01,
    ARC_SAMPLE = 2'b11,
    ARC_CONVERT = 2'b10
  } arc_state_t;

  // Towards the analog core
  typedef struct packed {
    logic on;
    logic [ARC_CHAN_W-1:0] channel;
    logic sample;
    logic convert;
    logic clk_en;
  } arc_core_req_t;

  // From the analog core, same clock
  typedef struct packed {
    logic [ARC_RESULT_W-1:0] result;
    logic done;
  } arc_core_rsp_t;

endpackage : arc_pkg

// >>> hw/arc_prescale.sv
`timescale 1ns/10ps
module arc_prescale
  import arc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [arc_pkg::ARC_PRESCALE_W-1:0] select,
  output logic tick
);

  // ****************************************************************
  // Converter clock enable divider
  // ****************************************************************
  logic [3:0] cnt_q;
  logic [3:0] mask;

  // Largest selected divisor wins; none selected ticks every cycle
  always_comb
  begin
    if (select[ARC_PS_SIXTEEN])
      mask = 4'hf;
    else if (select[ARC_PS_EIGHT])
      mask = 4'h7;
    else if (select[ARC_PS_FOUR])
      mask = 4'h3;
    else if (select[ARC_PS_TWO])
      mask = 4'h1;
    else
      mask = 4'h0;
  end

  // Free-running count; masked low bits give every power-of-two rate up to sixteen
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cnt_q <= 4'h0;
    else
      cnt_q <= cnt_q + 4'h1;
  end

  // One-cycle enable pulse, not a real clock, to stay in one domain
  assign tick = ((cnt_q & mask) == mask);

endmodule : arc_prescale

// >>> hw/arc_top.sv
// How it works
// - Raw byte mirrors core result live
// - Held result replaced only at completion
// - Low register bits 7:6 hold LSBs
// - High byte read latches low bits
// - Low bits keep the last latched value, zero after reset, until high byte read
// - Divide-by-sixteen bit selects sixteen
// - Divide-by-eight bit selects eight
// - Divide-by-four bit selects four
// - Divide-by-two bit selects two
// - Start bit begins conversion, reads busy
// - Cleared enable holds converter off
// - Channel field selects input n
`timescale 1ns/10ps
module arc_top
  import arc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [arc_pkg::ARC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [arc_pkg::ARC_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [arc_pkg::ARC_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [arc_pkg::ARC_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output arc_pkg::arc_core_req_t core_req,
  input wire arc_pkg::arc_core_rsp_t core_rsp
);

  import arc_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic aw_held_q;
  logic [ARC_ADDR_W-1:0] aw_addr_q;
  logic w_held_q;
  logic [7:0] w_byte_q;
  logic w_lane_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [ARC_DATA_W-1:0] rdata_q;
  logic [1:0] rresp_q;
  logic wr_fire;
  logic rd_fire;
  logic wr_hit;
  logic [11:0] wr_idx;
  logic [11:0] rd_idx;
  logic wr_ok;
  logic rd_ok;
  logic [7:0] rd_byte;

  logic [7:0] ctrl_q;
  logic busy_q;
  logic [ARC_SETTLE_W-1:0] settle_cycles_q;
  logic [ARC_HOLD_W-1:0] hold_cycles_q;
  logic [ARC_PRESCALE_W-1:0] prescale_q;
  logic [ARC_RESULT_W-1:0] held_result_q;
  logic [1:0] result_low_field_q;
  arc_state_t state_q;
  logic [ARC_HOLD_W-1:0] cnt_q;
  logic start_req;
  logic conv_tick;
  logic converter_on;
  logic [ARC_CHAN_W-1:0] input_channel_select;

  assign converter_on = ctrl_q[ARC_CTRL_ON_BIT];
  assign input_channel_select = ctrl_q[ARC_CTRL_CHAN_LSB +: ARC_CHAN_W];

  // ****************************************************************
  // AXI4-Lite write channel
  // ****************************************************************
  // Address and data taken in either order, one write at a time
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready = !w_held_q && !bvalid_q;
  assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
  assign wr_idx = aw_addr_q[13:2];
  assign wr_ok = (aw_addr_q[1:0] == 2'b00) && (aw_addr_q[15:14] == 2'b00) &&
                 (wr_idx >= ARC_IDX_CTRL) && (wr_idx <= ARC_IDX_PRESCALE);
  // Only byte lane 0 carries register data
  assign wr_hit = wr_fire && wr_ok && w_lane_q;

  // Write address holder
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      aw_addr_q <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end
    else if (wr_fire)
      aw_held_q <= 1'b0;
  end

  // Write data holder
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held_q <= 1'b0;
      w_byte_q <= 8'h00;
      w_lane_q <= 1'b0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_q <= 1'b1;
      w_byte_q <= s_axi_wdata[7:0];
      w_lane_q <= s_axi_wstrb[0];
    end
    else if (wr_fire)
      w_held_q <= 1'b0;
  end

  // Write response, error for unmapped or misaligned address
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= ARC_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_ok ? ARC_RESP_OKAY : ARC_RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_q <= 1'b0;
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // ****************************************************************
  // AXI4-Lite read channel
  // ****************************************************************
  assign s_axi_arready = !rvalid_q;
  assign rd_fire = s_axi_arvalid && !rvalid_q;
  assign rd_idx = s_axi_araddr[13:2];
  assign rd_ok = (s_axi_araddr[1:0] == 2'b00) && (s_axi_araddr[15:14] == 2'b00) &&
                 (rd_idx >= ARC_IDX_CTRL) && (rd_idx <= ARC_IDX_PRESCALE);

  // Read multiplexer; reserved bits read as zero, except control bits 6:5 and 3, which read back as written
  always_comb
  begin
    rd_byte = 8'h00;
    if (rd_idx == ARC_IDX_CTRL)
    begin
      rd_byte = ctrl_q;
      rd_byte[ARC_CTRL_START_BIT] = busy_q;
    end
    else if (rd_idx == ARC_IDX_RAW_HIGH)
      rd_byte = core_rsp.result[ARC_RESULT_W-1 -: 8];
    else if (rd_idx == ARC_IDX_HELD_HIGH)
      rd_byte = held_result_q[ARC_RESULT_W-1 -: 8];
    else if (rd_idx == ARC_IDX_HELD_LOW)
      rd_byte = {result_low_field_q, 6'h00};
    else if (rd_idx == ARC_IDX_SETTLE)
      rd_byte = {3'h0, settle_cycles_q};
    else if (rd_idx == ARC_IDX_HOLD)
      rd_byte = {2'h0, hold_cycles_q};
    else if (rd_idx == ARC_IDX_PRESCALE)
      rd_byte = {4'h0, prescale_q};
  end

  // Read data registered; raw byte is sampled at acceptance
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= ARC_RESP_OKAY;
    end
    else if (rd_fire)
    begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_ok ? {24'h000000, rd_byte} : '0;
      rresp_q <= rd_ok ? ARC_RESP_OKAY : ARC_RESP_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_q <= 1'b0;
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // ****************************************************************
  // Software registers
  // ****************************************************************
  // Control byte; start bit is not stored here, busy stands in for it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctrl_q <= ARC_CTRL_RESET;
    else if (wr_hit && wr_idx == ARC_IDX_CTRL)
    begin
      ctrl_q <= w_byte_q;
      ctrl_q[ARC_CTRL_START_BIT] <= 1'b0;
    end
  end

  // Cycle counts; software is trusted to meet the analog minimums
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      settle_cycles_q <= ARC_SETTLE_RESET;
      hold_cycles_q <= ARC_HOLD_RESET;
    end
    else if (wr_hit && wr_idx == ARC_IDX_SETTLE)
      settle_cycles_q <= w_byte_q[ARC_SETTLE_W-1:0];
    else if (wr_hit && wr_idx == ARC_IDX_HOLD)
      hold_cycles_q <= w_byte_q[ARC_HOLD_W-1:0];
  end

  // Prescale; reserved upper bits dropped
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      prescale_q <= ARC_PRESCALE_RESET;
    else if (wr_hit && wr_idx == ARC_IDX_PRESCALE)
      prescale_q <= w_byte_q[ARC_PRESCALE_W-1:0];
  end

  // ****************************************************************
  // Conversion sequencer
  // ****************************************************************
  // Writing one starts only when idle and enabled; zero does nothing
  assign start_req = wr_hit && (wr_idx == ARC_IDX_CTRL) &&
                     w_byte_q[ARC_CTRL_START_BIT] && w_byte_q[ARC_CTRL_ON_BIT] &&
                     (state_q == ARC_IDLE);

  // Counts of zero act as one cycle so the sequence never stalls
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= ARC_IDLE;
      cnt_q <= '0;
    end
    else if (!converter_on && !start_req)
    begin
      state_q <= ARC_IDLE;
      cnt_q <= '0;
    end
    else
    begin
      case (state_q)
        ARC_IDLE:
        begin
          if (start_req)
          begin
            state_q <= ARC_SETTLE;
            cnt_q <= {1'b0, settle_cycles_q};
          end
        end
        ARC_SETTLE:
        begin
          if (cnt_q <= 6'h01)
          begin
            state_q <= ARC_SAMPLE;
            cnt_q <= hold_cycles_q;
          end
          else
            cnt_q <= cnt_q - 6'h01;
        end
        ARC_SAMPLE:
        begin
          if (cnt_q <= 6'h01)
            state_q <= ARC_CONVERT;
          else
            cnt_q <= cnt_q - 6'h01;
        end
        ARC_CONVERT:
        begin
          if (core_rsp.done)
            state_q <= ARC_IDLE;
        end
        default:
          state_q <= ARC_IDLE;
      endcase
    end
  end

  // Busy flag, read back in the start position
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      busy_q <= 1'b0;
    else if (start_req)
      busy_q <= 1'b1;
    else if (state_q == ARC_IDLE)
      busy_q <= 1'b0;
  end

  // ****************************************************************
  // Result holding
  // ****************************************************************
  // Previous result stays until the core reports a finished conversion
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      held_result_q <= '0;
    else if (state_q == ARC_CONVERT && core_rsp.done && converter_on)
      held_result_q <= core_rsp.result;
  end

  // Low bits follow the high byte read, keeping the pair coherent
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      result_low_field_q <= 2'b00;
    else if (rd_fire && rd_ok && rd_idx == ARC_IDX_HELD_HIGH)
      result_low_field_q <= held_result_q[1:0];
  end

  // ****************************************************************
  // Core side
  // ****************************************************************
  arc_prescale u_prescale
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .select(prescale_q),
    .tick(conv_tick)
  );

  // Clock enable gated off with the converter to save power
  always_comb
  begin
    core_req.on = converter_on;
    core_req.channel = input_channel_select;
    core_req.sample = (state_q == ARC_SAMPLE);
    core_req.convert = (state_q == ARC_CONVERT);
    core_req.clk_en = conv_tick && converter_on;
  end

endmodule : arc_top

// >>> dv/arc_core_model.sv
`timescale 1ns/10ps
module arc_core_model
  import arc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire arc_pkg::arc_core_req_t core_req,
  input wire logic [arc_pkg::ARC_RESULT_W-1:0] target,
  output arc_pkg::arc_core_rsp_t core_rsp
);
  logic [3:0] step_q;

  // One result bit per converter clock, MSB first, so the live value moves
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      step_q <= 4'h0;
      core_rsp <= '0;
    end
    else if (!core_req.convert || !core_req.on)
    begin
      step_q <= 4'h0;
      core_rsp.done <= 1'b0;
    end
    else if (core_req.clk_en && step_q < 4'ha)
    begin
      step_q <= step_q + 4'h1;
      core_rsp.result <= (step_q == 4'h0 ? 10'h0 : core_rsp.result) | (target & (10'h200 >> step_q));
      core_rsp.done <= (step_q == 4'h9);
    end
    else
      core_rsp.done <= 1'b0;
  end
endmodule : arc_core_model

// >>> dv/arc_top_sva.sv
`timescale 1ns/10ps
module arc_top_sva
  import arc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [arc_pkg::ARC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [arc_pkg::ARC_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [arc_pkg::ARC_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [arc_pkg::ARC_DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire arc_pkg::arc_core_req_t core_req,
  input wire arc_pkg::arc_core_rsp_t core_rsp
);
  // ****************************************************************
  // Bus and sequencer checks
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read request not answered");
  read_origin_a: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid))
    else $error("read answer without request");
  read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  write_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  byte_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bytes not zero");
  clk_off_a: assert property (!core_req.on |-> !core_req.clk_en)
    else $error("converter clock runs while off");
  phase_off_a: assert property (!core_req.on |=> !core_req.sample && !core_req.convert)
    else $error("sequencer active while off");
  phase_order_a: assert property ($rose(core_req.convert) |-> $past(core_req.sample))
    else $error("convert without preceding sample");
  phase_excl_a: assert property (!(core_req.sample && core_req.convert))
    else $error("sample and convert together");
  done_ends_a: assert property (core_rsp.done && core_req.convert |=> !core_req.convert)
    else $error("convert held after done");

  // Main scenarios reached
  cover property (s_axi_rvalid && s_axi_rresp == ARC_RESP_SLVERR);
  cover property (core_rsp.done && core_req.convert);
  cover property ($fell(core_req.sample) && core_req.convert);
endmodule : arc_top_sva

// >>> dv/arc_top_bench.sv
`timescale 1ns/10ps
`define ARC_CHK(g, e) \
  begin \
    samples_checked++; \
    if ((g) !== (e)) \
    begin \
      mismatches++; \
      $display("unexpected at %0t got %h expected %h", $time, (g), (e)); \
    end \
  end
module arc_top_bench;
  import arc_pkg::*;
  localparam logic [1:0] OK = ARC_RESP_OKAY;
  localparam logic [7:0] PS_SEL [7] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h00, 8'h06, 8'h0f};
  localparam int PS_DIV [7] = '{2, 4, 8, 16, 1, 8, 16};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [ARC_ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  arc_core_req_t core_req;
  arc_core_rsp_t core_rsp;
  logic [9:0] target = '0;
  logic [33:0] exp_q [$], mask_q [$], got, m, e;
  int mismatches = 0, samples_checked = 0, cycles = 0, sample_len = 0, en_cnt = 0;

  arc_top arc_top_inst (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_awprot, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .core_req, .core_rsp);
  arc_core_model arc_core_model_inst (.aclk, .aresetn, .core_req, .target, .core_rsp);

  // 25 MHz system clock
  initial forever #20 aclk = ~aclk;

  function automatic logic [15:0] ba(input logic [11:0] i);
    return {2'b00, i, 2'b00};
  endfunction : ba

  task automatic print_verdict;
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : print_verdict

  // Both halves offered together; each released once taken
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [1:0] r);
    exp_q.push_back({r, 32'h0});
    mask_q.push_back({2'h3, 32'h0});
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
    do @(posedge aclk); while (!s_axi_bvalid);
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [1:0] r, input logic [31:0] ev,
    input logic [31:0] mv, output logic [31:0] d);
    exp_q.push_back({r, ev & mv});
    mask_q.push_back({2'h3, mv});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
  endtask : rd

  // Watcher: compares each bus answer with the oldest note; also counts and times out
  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    if (core_req.sample) sample_len <= sample_len + 1;
    if (core_req.clk_en) en_cnt <= en_cnt + 1;
    if (s_axi_rvalid || s_axi_bvalid)
    begin
      got = {s_axi_rvalid ? s_axi_rresp : s_axi_bresp, s_axi_rvalid ? s_axi_rdata : 32'h0};
      m = mask_q.pop_front();
      e = exp_q.pop_front();
      `ARC_CHK(got & m, e)
    end
    if (cycles > 20000)
    begin
      mismatches++;
      print_verdict();
    end
  end

  // Main sequence
  initial
  begin
    logic [31:0] d;
    logic [9:0] t1, prev;
    logic [2:0] ch;
    int s, h, n0;
    void'($urandom(71));
    prev = 10'h0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(ba(ARC_IDX_SETTLE), OK, 32'h1f, '1, d);
    rd(ba(ARC_IDX_HOLD), OK, 32'h3f, '1, d);
    rd(ba(ARC_IDX_PRESCALE), OK, 32'h0, '1, d);
    rd(ba(ARC_IDX_CTRL), OK, 32'h0, '1, d);
    rd(16'h3de0, ARC_RESP_SLVERR, 32'h0, '1, d);
    wr(16'h3dc1, 8'h00, ARC_RESP_SLVERR);
    // Divider rates; settle 16 cycles so an old count cannot skew the window
    wr(ba(ARC_IDX_CTRL), 8'h10, OK);
    for (int i = 0; i < 7; i++)
    begin
      wr(ba(ARC_IDX_PRESCALE), PS_SEL[i], OK);
      rd(ba(ARC_IDX_PRESCALE), OK, {24'h0, PS_SEL[i]}, '1, d);
      repeat (16) @(posedge aclk);
      n0 = en_cnt;
      repeat (64) @(posedge aclk);
      `ARC_CHK(en_cnt - n0, 64 / PS_DIV[i])
    end
    wr(ba(ARC_IDX_PRESCALE), 8'h00, OK);
    // Counts for 0.5 us and 1 us at 40 ns: at least 13 and 25 cycles
    s = 13 + $urandom_range(18);
    h = 25 + $urandom_range(38);
    wr(ba(ARC_IDX_SETTLE), 8'(s), OK);
    wr(ba(ARC_IDX_HOLD), 8'(h), OK);
    rd(ba(ARC_IDX_HOLD), OK, h, '1, d);
    for (int k = 0; k < 3; k++)
    begin
      t1 = 10'($urandom);
      ch = 3'($urandom);
      n0 = sample_len;
      target <= t1;
      wr(ba(ARC_IDX_CTRL), 8'h90 | ch, OK);
      `ARC_CHK(core_req.channel, ch)
      rd(ba(ARC_IDX_CTRL), OK, 32'h80, 32'h80, d);
      wr(ba(ARC_IDX_CTRL), 8'h10 | ch, OK);
      rd(ba(ARC_IDX_HELD_HIGH), OK, prev[9:2], k ? '1 : '0, d);
      d = 32'h80;
      while (d[7]) rd(ba(ARC_IDX_CTRL), OK, 32'h0, 32'h0, d);
      `ARC_CHK(sample_len - n0, h)
      rd(ba(ARC_IDX_RAW_HIGH), OK, t1[9:2], '1, d);
      rd(ba(ARC_IDX_HELD_LOW), OK, {prev[1:0], 6'h0}, k ? '1 : '0, d);
      rd(ba(ARC_IDX_HELD_HIGH), OK, t1[9:2], '1, d);
      rd(ba(ARC_IDX_HELD_LOW), OK, {t1[1:0], 6'h0}, '1, d);
      prev = t1;
    end
    // Abort by clearing the enable, then a start without enable
    target <= ~prev;
    wr(ba(ARC_IDX_CTRL), 8'h90, OK);
    wr(ba(ARC_IDX_CTRL), 8'h00, OK);
    // Busy falls one cycle after the sequencer has gone back to idle
    @(posedge aclk);
    rd(ba(ARC_IDX_CTRL), OK, 32'h0, 32'h80, d);
    wr(ba(ARC_IDX_CTRL), 8'h80, OK);
    rd(ba(ARC_IDX_CTRL), OK, 32'h0, 32'h80, d);
    n0 = en_cnt;
    repeat (32) @(posedge aclk);
    `ARC_CHK(en_cnt - n0, 0)
    rd(ba(ARC_IDX_HELD_HIGH), OK, prev[9:2], '1, d);
    print_verdict();
  end
endmodule : arc_top_bench

bind arc_top arc_top_sva arc_top_sva_inst (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_awaddr, .s_axi_awprot, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
  .s_axi_arprot, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .core_req, .core_rsp);
